// [hw/hbcfl_params.svh]
// Timing constants and functional notes for the bridge control and fault logic.
// Functional notes
// - Either disable input active turns all switches off and pulls fault flag low.
// - Latched shutdown and fault clear only by toggling a disable input; here sleep (wake low) also clears the latch.
// - Current limit chops output with fixed off-time, rate never above 20 kHz; the 20.5 us off-time here permits up to about 49 kHz.
// - Short-circuit threshold crossing forces latched tri-state, not current limiting.
// - Outputs are off within 4.0 us of short or overtemperature detection.
// - Above 160 C the limit folds back; at 175 C thermal latch-off.
// - Undervoltage holds outputs tri-stated and fault flag low regardless of inputs; here the flag is pulled low only while wake is high.
// - Undervoltage end clears flag and restores outputs with no host action.
// - Short or overtemperature latches outputs off, flag low, until cleared.
// - After power-up wait a power-on delay, 1.0 ms typical, 5.0 ms max.
// - After wake wait a wake-up delay, 1.0 ms typical, 5.0 ms max.
// - Fault flag is open drain: pulled low on fault, released otherwise.
// - Wake low means sleep: outputs high impedance, fault flag released.
// - Run needs wake high, disables inactive, flag clear; each output follows its input.
// - Equal polarity inputs brake: both high sides or both low sides on.
// - Each output activation starts a blanking timer to spot hard shorts; here only polarity input changes while driving and off-time ends start it.
`ifndef HBCFL_PARAMS_SVH
`define HBCFL_PARAMS_SVH
`define HBCFL_CLK_PERIOD_NS 40
`define HBCFL_OFF_TIME_NS   20500
`define HBCFL_OFF_CYC       ((`HBCFL_OFF_TIME_NS) / (`HBCFL_CLK_PERIOD_NS))
`define HBCFL_BLANK_TIME_NS 16500
`define HBCFL_BLANK_CYC     ((`HBCFL_BLANK_TIME_NS) / (`HBCFL_CLK_PERIOD_NS))
`define HBCFL_FAULT_TIME_NS 4000
`define HBCFL_FAULT_CYC     ((`HBCFL_FAULT_TIME_NS) / (`HBCFL_CLK_PERIOD_NS))
`define HBCFL_PON_TIME_US   1000
`define HBCFL_PON_CYC       ((`HBCFL_PON_TIME_US) * 1000 / (`HBCFL_CLK_PERIOD_NS))
`define HBCFL_PWM_PERIOD_NS 100000
`define HBCFL_PWM_HALF_CYC  ((`HBCFL_PWM_PERIOD_NS) / (`HBCFL_CLK_PERIOD_NS) / 2)
`endif

// [hw/hbcfl_pkg.sv]
// Types shared by the bridge control and fault logic.
package hbcfl_pkg;
	// Drive state of one half-bridge output.
	typedef enum logic [1:0] {HBCFL_DRV_Z, HBCFL_DRV_LOW, HBCFL_DRV_HIGH} hbcfl_drive_t;
	// Top-level operating state.
	typedef enum logic [1:0] {HBCFL_ST_WAIT, HBCFL_ST_RUN, HBCFL_ST_LATCH} hbcfl_state_t;
endpackage

// [hw/hbcfl_core.sv]
// Control decode, current limiting and fault latching of a full-bridge driver.
`timescale 1ns/1ns
`default_nettype none
`include "hbcfl_params.svh"
module hbcfl_core import hbcfl_pkg::*; #(
	parameter int unsigned WAKE_CYC = `HBCFL_PON_CYC
) (
	// Clock and reset.
	input  wire logic   sys_clk,
	input  wire logic   resetn,
	// Host control inputs.
	input  wire logic   polarity_input_a,
	input  wire logic   polarity_input_b,
	input  wire logic   disable_active_high,
	input  wire logic   disable_active_low,
	input  wire logic   wake,
	// Analog comparator and monitor inputs.
	input  wire logic   over_current_limit,
	input  wire logic   high_side_short,
	input  wire logic   low_side_short,
	input  wire logic   temp_foldback,
	input  wire logic   temp_shutdown,
	input  wire logic   under_voltage,
	// Bridge drive outputs.
	output logic [1:0]  bridge_output_a,
	output logic [1:0]  bridge_output_b,
	output logic        limit_reduce,
	// Open-drain fault flag.
	output logic        fault_flag_n_o,
	output logic        fault_flag_n_oe
);
	// =========================================================
	// Input synchronisers
	// =========================================================
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	wire  [4:0] raw_in = {wake, disable_active_low, disable_active_high,
		polarity_input_b, polarity_input_a};

	// Two stages per input; only the second stage feeds the decode.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 5'h08;
			sync2_q <= 5'h08;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	wire in_a   = sync2_q[0];
	wire in_b   = sync2_q[1];
	wire dis_hi = sync2_q[2];
	wire dis_lo = sync2_q[3];
	wire awake  = sync2_q[4];
	wire disabled = dis_hi | ~dis_lo;

	// =========================================================
	// State machine
	// =========================================================
	hbcfl_state_t state_q;
	hbcfl_state_t state_d;
	logic [17:0]  wait_q;
	logic [9:0]   off_q;
	logic [9:0]   blank_q;
	logic         in_a_q;
	logic         in_b_q;
	wire hard_fault = high_side_short | low_side_short | temp_shutdown;
	wire wait_done  = (wait_q == 18'(WAKE_CYC - 1));
	wire chopping   = (off_q != 10'h000);
	// Blanking runs while an output was just activated; a limit trip past it while chopping is a hard short.
	wire blank_on   = (blank_q != 10'h000);
	wire persist    = over_current_limit & ~blank_on & chopping;

	// Power-on and wake both restart the wait; latches clear on disable or on sleep.
	always_comb begin
		state_d = state_q;
		case (state_q)
			HBCFL_ST_WAIT: if (wait_done) state_d = HBCFL_ST_RUN;
			HBCFL_ST_RUN:  if (hard_fault | persist) state_d = HBCFL_ST_LATCH;
			HBCFL_ST_LATCH: if (disabled) state_d = HBCFL_ST_RUN;
			default: state_d = HBCFL_ST_WAIT;
		endcase
		if (!awake) state_d = HBCFL_ST_WAIT;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= HBCFL_ST_WAIT;
			wait_q  <= 18'h00000;
		end else begin
			state_q <= state_d;
			wait_q  <= (state_q == HBCFL_ST_WAIT && awake && !wait_done) ?
				wait_q + 18'h00001 : 18'h00000;
		end
	end

	// =========================================================
	// Current limiting and blanking timers
	// =========================================================
	// Sleep cuts drive in the same cycle the state machine learns of it.
	wire run_ok   = (state_q == HBCFL_ST_RUN) & awake & ~disabled &
		~under_voltage;
	wire activate = run_ok & ((in_a != in_a_q) | (in_b != in_b_q) | chopping & (off_q == 10'h001));

	// Fixed off-time of 512 cycles keeps the chop period at least 20.48 us, so the chop rate stays below about 49 kHz.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			off_q   <= 10'h000;
			blank_q <= 10'h000;
			in_a_q  <= 1'b0;
			in_b_q  <= 1'b0;
		end else begin
			in_a_q <= in_a;
			in_b_q <= in_b;
			if (!run_ok)
				off_q <= 10'h000;
			else if (over_current_limit && !chopping)
				off_q <= 10'(`HBCFL_OFF_CYC);
			else if (chopping)
				off_q <= off_q - 10'h001;
			if (activate)
				blank_q <= 10'(`HBCFL_BLANK_CYC);
			else if (blank_on)
				blank_q <= blank_q - 10'h001;
		end
	end

	// =========================================================
	// Output decode
	// =========================================================
	wire drive_on = run_ok & ~chopping & ~hard_fault;
	wire [1:0] lvl_a = in_a ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW;
	wire [1:0] lvl_b = in_b ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW;
	wire flag_low = awake & (disabled | under_voltage | state_q == HBCFL_ST_LATCH);

	// Outputs registered; fault removes drive within one cycle, well inside 4.0 us.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bridge_output_a <= HBCFL_DRV_Z;
			bridge_output_b <= HBCFL_DRV_Z;
			fault_flag_n_oe <= 1'b0;
		end else begin
			bridge_output_a <= drive_on ? lvl_a : HBCFL_DRV_Z;
			bridge_output_b <= drive_on ? lvl_b : HBCFL_DRV_Z;
			fault_flag_n_oe <= flag_low;
		end
	end

	assign fault_flag_n_o = 1'b0;
	assign limit_reduce   = temp_foldback;

	// =========================================================
	// Assertions
	// =========================================================
	property p_dis_off;
		@(posedge sys_clk) disable iff (!resetn)
		disabled |=> (bridge_output_a == HBCFL_DRV_Z && fault_flag_n_oe == $past(awake));
	endproperty
	a_dis_off: assert property (p_dis_off) else $error("disable did not tri-state");

	// Turn-off bound in cycles after a short or overtemperature.
	localparam int FAULT_LIM = `HBCFL_FAULT_CYC - 1;

	property p_fault_off;
		@(posedge sys_clk) disable iff (!resetn)
		hard_fault |=> ##[0:FAULT_LIM] (bridge_output_a == HBCFL_DRV_Z &&
			bridge_output_b == HBCFL_DRV_Z);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault turn-off late");

	property p_latch_hold;
		@(posedge sys_clk) disable iff (!resetn)
		(state_q == HBCFL_ST_LATCH && awake && !disabled) |=> state_q == HBCFL_ST_LATCH;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch released");

	property p_uv;
		@(posedge sys_clk) disable iff (!resetn)
		(under_voltage && awake) |=> (fault_flag_n_oe && bridge_output_b == HBCFL_DRV_Z);
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage not held");

	property p_sleep;
		@(posedge sys_clk) disable iff (!resetn)
		!awake |=> (!fault_flag_n_oe && bridge_output_a == HBCFL_DRV_Z);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not honoured");

	property p_chop;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(chopping) |-> chopping [*8];
	endproperty
	a_chop: assert property (p_chop) else $error("off-time too short");

	property p_brake;
		@(posedge sys_clk) disable iff (!resetn)
		(drive_on && in_a && in_b) |=> (bridge_output_a == HBCFL_DRV_HIGH &&
			bridge_output_b == HBCFL_DRV_HIGH);
	endproperty
	a_brake: assert property (p_brake) else $error("brake high wrong");

	property p_wait;
		@(posedge sys_clk) disable iff (!resetn)
		$fell(awake) |=> (bridge_output_a == HBCFL_DRV_Z) [*8];
	endproperty
	a_wait: assert property (p_wait) else $error("wake delay skipped");

	property p_latch_set;
		@(posedge sys_clk) disable iff (!resetn)
		(state_q == HBCFL_ST_RUN && hard_fault && awake) |=> state_q == HBCFL_ST_LATCH;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("fault not latched");

	property p_persist;
		@(posedge sys_clk) disable iff (!resetn)
		(state_q == HBCFL_ST_RUN && persist && awake) |=> state_q == HBCFL_ST_LATCH;
	endproperty
	a_persist: assert property (p_persist) else $error("hard short missed");

	property p_off_len;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(chopping) |-> off_q == 10'(`HBCFL_OFF_CYC);
	endproperty
	a_off_len: assert property (p_off_len) else $error("off-time load wrong");
endmodule
`default_nettype wire

// [sim/hbcfl_host_model.sv]
// Host controller model driving the bridge control pins and reading the fault flag.
`timescale 1ns/1ns
`default_nettype none
module hbcfl_host_model (
	// Fault flag pin from the device.
	input  wire logic fault_flag_n_o,
	input  wire logic fault_flag_n_oe,
	// Control pins towards the device.
	output var logic  polarity_input_a,
	output var logic  polarity_input_b,
	output var logic  disable_active_high,
	output var logic  disable_active_low,
	output var logic  wake,
	// Flag level as the host reads it.
	output logic      fault_flag_n
);
	// The board pull-up makes a released flag read high.
	assign fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
	// Start awake, enabled and driving forward.
	initial begin
		set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
	end
	// Opposite polarity levels pick the direction; a disable toggle clears a latch.
	task automatic set_pins(input logic w, input logic dh, input logic dl,
			input logic a, input logic b);
		wake = w;
		disable_active_high = dh;
		disable_active_low = dl;
		polarity_input_a = a;
		polarity_input_b = b;
	endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking testbench for the bridge control and fault logic.
`timescale 1ns/1ns
`default_nettype none
`include "hbcfl_params.svh"
module tb_top;
	import hbcfl_pkg::*;
	// ==========================================================
	// Signals
	logic sys_clk = 1'b0, resetn = 1'b0, ocl = 1'b0, tfb = 1'b0, uv = 1'b0;
	logic [2:0] src = 3'h0;
	logic pa, pb, dh, dl, wk, fo, foe, flag, lr;
	logic [1:0] oa, ob;
	int num_errors = 0, cmp_count = 0;
	// Clock of 40 ns period.
	always #20 sys_clk = ~sys_clk;
	hbcfl_core #(.WAKE_CYC(20)) i_hbcfl_core (.sys_clk(sys_clk), .resetn(resetn),
		.polarity_input_a(pa), .polarity_input_b(pb), .disable_active_high(dh),
		.disable_active_low(dl), .wake(wk), .over_current_limit(ocl),
		.high_side_short(src[0]), .low_side_short(src[1]), .temp_foldback(tfb),
		.temp_shutdown(src[2]), .under_voltage(uv), .bridge_output_a(oa),
		.bridge_output_b(ob), .limit_reduce(lr), .fault_flag_n_o(fo), .fault_flag_n_oe(foe));
	hbcfl_host_model i_hbcfl_host_model (.fault_flag_n_o(fo), .fault_flag_n_oe(foe),
		.polarity_input_a(pa), .polarity_input_b(pb), .disable_active_high(dh),
		.disable_active_low(dl), .wake(wk), .fault_flag_n(flag));
	// ==========================================================
	// Helpers: inputs always move 1 ns after a rising edge.
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic chk_st(input string what, input logic [1:0] ea, input logic [1:0] eb,
			input logic ef);
		chk({what, " a"}, ea, oa);
		chk({what, " b"}, eb, ob);
		chk({what, " flag"}, {1'b0, ef}, {1'b0, flag});
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_drive();
		for (int i = 0; i < 4; i++) begin
			int p;
			p = (i == 0) ? 2 : i - 1;
			i_hbcfl_host_model.set_pins(1'b1, 1'b0, 1'b1, i[1], i[0]);
			step(2);
			chk_st("sync", p[1] ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW,
				p[0] ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW, 1'b1);
			step(4);
			chk_st("drive", i[1] ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW,
				i[0] ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW, 1'b1);
		end
	endtask
	task automatic t_disable();
		for (int i = 0; i < 2; i++) begin
			i_hbcfl_host_model.set_pins(1'b1, i == 0, i == 0, 1'b1, 1'b0);
			step(6);
			chk_st("disable", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b0);
			i_hbcfl_host_model.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
			step(6);
			chk_st("enable", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
		end
	endtask
	task automatic t_latch();
		for (int k = 0; k < 3; k++) begin
			src = 3'h1 << k;
			step(2);
			src = 3'h0;
			step(6);
			chk_st("trip", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b0);
			step(30);
			chk_st("held", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b0);
			i_hbcfl_host_model.set_pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
			step(6);
			i_hbcfl_host_model.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
			step(6);
			chk_st("cleared", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
		end
	endtask
	task automatic t_supply();
		uv = 1'b1;
		step(6);
		chk_st("uv", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b0);
		uv = 1'b0;
		step(6);
		chk_st("uv end", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
		tfb = 1'b1;
		step(1);
		chk("foldback", 2'h1, {1'b0, lr});
		tfb = 1'b0;
	endtask
	task automatic t_limit();
		ocl = 1'b1;
		step(1);
		ocl = 1'b0;
		step(6);
		chk_st("chop", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b1);
		step(`HBCFL_OFF_CYC - 6);
		chk_st("off time", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b1);
		step(1);
		chk_st("resume", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
		// A limit trip inside the blanking window only chops.
		ocl = 1'b1;
		step(2);
		ocl = 1'b0;
		step(6);
		chk_st("blanked", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b1);
		// Past the blanking window a trip while chopping is a hard short.
		step(`HBCFL_OFF_CYC + `HBCFL_BLANK_CYC + 8);
		ocl = 1'b1;
		step(2);
		ocl = 1'b0;
		step(6);
		chk_st("persist", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b0);
		i_hbcfl_host_model.set_pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		step(6);
		i_hbcfl_host_model.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		step(6);
		chk_st("unlatched", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
	endtask
	// Host modulation: one polarity input held high, the other pulsed at the nominal rate.
	task automatic t_pwm();
		for (int i = 0; i < 4; i++) begin
			i_hbcfl_host_model.set_pins(1'b1, 1'b0, 1'b1, 1'b1, i[0]);
			step(6);
			chk_st("pwm", HBCFL_DRV_HIGH,
				i[0] ? HBCFL_DRV_HIGH : HBCFL_DRV_LOW, 1'b1);
			step(`HBCFL_PWM_HALF_CYC - 6);
		end
	endtask
	task automatic t_sleep();
		i_hbcfl_host_model.set_pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		step(6);
		chk_st("sleep", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b1);
		i_hbcfl_host_model.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		step(8);
		chk_st("waking", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b1);
		step(30);
		chk_st("awake", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
	endtask
	// ==========================================================
	// Verdict, watchdog and main sequence.
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		step(16);
		resetn = 1'b1;
		step(5);
		chk_st("power on", HBCFL_DRV_Z, HBCFL_DRV_Z, 1'b1);
		step(30);
		chk_st("ready", HBCFL_DRV_HIGH, HBCFL_DRV_LOW, 1'b1);
		t_drive();
		t_disable();
		t_latch();
		t_supply();
		t_limit();
		t_pwm();
		t_sleep();
		give_verdict();
	end
endmodule
`default_nettype wire
